// ===== dv/coe_clk_ctrl_tb.sv
// Testbench for the clock output enable control block
`timescale 1ns/1ns
`default_nettype none
`include "coe_regs.vh"
module coe_clk_ctrl_tb;
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       ref_clk_true = 1'b0;
    logic       pll_supply_strap = 1'b0;
    logic       scl, sda_low, sda_oe, fb_out_oe_q, pll_on_q;
    logic [9:0] out_clk_oe;
    logic [9:0] exp_oe = 10'h3FF;
    logic [4:0] acks;
    int         miscompares = 0;
    int         num_checks = 0;
    int         ref_hi = 62;
    int         ref_lo = 63;
    wire        sda = !(sda_low || sda_oe);
    always #5 clk = ~clk;
    // Half periods keep every reference edge off the system clock edge
    initial #1 forever begin
        ref_clk_true = 1'b1;
        #(ref_hi);
        ref_clk_true = 1'b0;
        #(ref_lo);
    end
    coe_clk_ctrl coe_clk_ctrl_i (.clk, .sys_rst, .ref_clk_true, .pll_supply_strap,
        .serial_clk_pin(scl), .serial_data_in(sda), .serial_data_out_q(),
        .serial_data_oe_q(sda_oe), .out_clk_true(), .out_clk_comp(), .out_clk_oe,
        .fb_out_true_q(), .fb_out_comp_q(), .fb_out_oe_q, .pll_on_q);
    coe_host coe_host_i (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_lvl(sda));
    ////////////////////////////////////////////////////////////////
    task automatic chk_oe(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t enables got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_ack(input logic [4:0] got, input logic [4:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t acks got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic t_power_up();
        repeat (20) @(posedge clk);
        chk_oe(out_clk_oe, 10'h3FF);
        chk_bit(fb_out_oe_q, 1'b1);
        chk_bit(pll_on_q, 1'b0);
    endtask
    task automatic t_write(input logic [7:0] d0, input logic [7:0] d1);
        coe_host_i.send({`COE_DEV_ADDR, 1'b0, 8'h00, 8'h02, d0, d1}, acks);
        chk_ack(acks, 5'h1F);
        for (int i = 0; i < 8; i++)
            exp_oe[i] = d0[7 - i];
        exp_oe[9:8] = {d1[6], d1[7]};
        repeat (16) @(posedge clk);
        chk_oe(out_clk_oe, exp_oe);
        chk_bit(fb_out_oe_q, 1'b1);
    endtask
    // Data differs from the held enables, so a wrongly taken write shows
    task automatic t_bad_addr(input logic [7:0] a);
        coe_host_i.send({a, 32'h0002_FFC0}, acks);
        chk_ack(acks, 5'h00);
        chk_oe(out_clk_oe, exp_oe);
    endtask
    // Bench reference is far below the floor, so strap high must float all
    task automatic t_slow_ref();
        pll_supply_strap <= 1'b1;
        repeat (12) @(posedge clk);
        chk_oe(out_clk_oe, 10'h000);
        chk_bit(fb_out_oe_q, 1'b0);
        chk_bit(pll_on_q, 1'b0);
        pll_supply_strap <= 1'b0;
        repeat (30) @(posedge clk);
        chk_oe(out_clk_oe, exp_oe);
        chk_bit(fb_out_oe_q, 1'b1);
    endtask
    // Reference sped up to three clocks a period: PLL path stays on
    task automatic t_fast_ref();
        ref_hi = 12;
        ref_lo = 18;
        repeat (30) @(posedge clk);
        pll_supply_strap <= 1'b1;
        repeat (12) @(posedge clk);
        chk_bit(pll_on_q, 1'b1);
        chk_bit(fb_out_oe_q, 1'b1);
        chk_oe(out_clk_oe, exp_oe);
        pll_supply_strap <= 1'b0;
        repeat (12) @(posedge clk);
        chk_bit(pll_on_q, 1'b0);
        ref_hi = 62;
        ref_lo = 63;
        repeat (30) @(posedge clk);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        t_power_up();
        t_write(8'hA5, 8'h80);
        t_write(8'h5A, 8'h7F);
        t_write(8'h00, 8'h3F);
        t_bad_addr(8'hD4);
        t_bad_addr(8'hD3);
        t_write(8'hFF, 8'hC0);
        t_slow_ref();
        t_fast_ref();
        t_write(8'h3C, 8'h40);
        close_out();
    end
    // Five writes and two bad-address sends take under twenty thousand cycles
    initial begin
        repeat (40000) @(posedge clk);
        $display("[ERR] %0t watchdog expired", $time);
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire

// ===== dv/coe_host.sv
// Serial bus host model writing the enable bytes
`timescale 1ns/1ns
`default_nettype none
module coe_host (
    // Clock
    input  wire logic clk,
    // Serial bus
    output var  logic scl,
    output var  logic sda_low,
    input  wire logic sda_lvl
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic hold();
        repeat (20) @(posedge clk);
    endtask
    // Data bits move four cycles after the clock falls; before the stop, data moves with it
    task automatic send(input logic [39:0] b, output logic [4:0] acks);
        sda_low <= 1'b1;
        hold();
        for (int i = 0; i < 45; i++) begin
            scl <= 1'b0;
            repeat (4) @(posedge clk);
            sda_low <= (i % 9 == 8) ? 1'b0 : !b[39 - (i / 9) * 8 - (i % 9)];
            hold();
            scl <= 1'b1;
            hold();
            if (i % 9 == 8)
                acks[4 - i / 9] = !sda_lvl;
        end
        scl <= 1'b0;
        sda_low <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_low <= 1'b0;
        hold();
    endtask
endmodule
`default_nettype wire

// ===== dv/coe_props.sv
// Port assertions for the clock output enable control block
`timescale 1ns/1ns
`default_nettype none
module coe_props (
    // Clock, reset, straps
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       ref_clk_true,
    input wire logic       pll_supply_strap,
    // Serial bus
    input wire logic       serial_clk_pin,
    input wire logic       serial_data_in,
    input wire logic       serial_data_out_q,
    input wire logic       serial_data_oe_q,
    // Outputs
    input wire logic [9:0] out_clk_true,
    input wire logic [9:0] out_clk_comp,
    input wire logic [9:0] out_clk_oe,
    input wire logic       fb_out_true_q,
    input wire logic       fb_out_comp_q,
    input wire logic       fb_out_oe_q,
    input wire logic       pll_on_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    sequence s_strap_low;
        (!pll_supply_strap)[*8];
    endsequence
    sequence s_strap_high;
        pll_supply_strap[*8];
    endsequence
    property p_fb_on;
        s_strap_low |-> fb_out_oe_q;
    endproperty
    a_fb_on: assert property (p_fb_on) else $error("feedback undriven");
    property p_bypass;
        s_strap_low |-> !pll_on_q;
    endproperty
    a_bypass: assert property (p_bypass) else $error("pll on in bypass");
    property p_slow;
        s_strap_high ##0 !pll_on_q |-> out_clk_oe == 10'h000 && !fb_out_oe_q;
    endproperty
    a_slow: assert property (p_slow) else $error("slow ref not floating");
    property p_comp;
        out_clk_comp == ~out_clk_true;
    endproperty
    a_comp: assert property (p_comp) else $error("pair not complementary");
    property p_fb_comp;
        fb_out_comp_q != fb_out_true_q;
    endproperty
    a_fb_comp: assert property (p_fb_comp) else $error("feedback not diff");
    // Enable edge may only land after a low sample of that pair
    property p_phase;
        $changed(out_clk_oe) && fb_out_oe_q && $past(fb_out_oe_q)
            |-> ($past(out_clk_true) & (out_clk_oe ^ $past(out_clk_oe))) == 10'h000;
    endproperty
    a_phase: assert property (p_phase) else $error("enable cut a pulse");
    property p_ack;
        $changed(serial_data_oe_q) |-> !serial_clk_pin;
    endproperty
    a_ack: assert property (p_ack) else $error("ack moved with clock high");
    property p_od;
        !serial_data_out_q;
    endproperty
    a_od: assert property (p_od) else $error("data pin driven high");
    // Outputs track the reference three samples late in bypass
    property p_follow;
        s_strap_low |-> fb_out_true_q == $past(ref_clk_true, 3) &&
            out_clk_true == {10{$past(ref_clk_true, 3)}};
    endproperty
    a_follow: assert property (p_follow) else $error("outputs not following ref");
endmodule
bind coe_clk_ctrl coe_props coe_props_i (.clk, .sys_rst, .ref_clk_true, .pll_supply_strap,
    .serial_clk_pin, .serial_data_in, .serial_data_out_q, .serial_data_oe_q, .out_clk_true,
    .out_clk_comp, .out_clk_oe, .fb_out_true_q, .fb_out_comp_q, .fb_out_oe_q, .pll_on_q);
`default_nettype wire

// ===== include/coe_regs.vh
// Constants for the clock output enable control block
`ifndef COE_REGS_VH
`define COE_REGS_VH

// Serial bus: 7-bit device address and byte positions in a write
`define COE_DEV_ADDR        7'h69
`define COE_IDX_ADDR        3'h0
`define COE_IDX_CMD         3'h1
`define COE_IDX_COUNT       3'h2
`define COE_IDX_EN_LOW      3'h3
`define COE_IDX_EN_HIGH     3'h4
`define COE_IDX_LAST        3'h5

// Enable register layout and power-up values
`define COE_EN_LOW_RST      8'hFF
`define COE_EN_HIGH_RST     8'hC0
`define COE_EN_HIGH_PAIR8   7
`define COE_EN_HIGH_PAIR9   6

// Reference frequency floor (design figure) against system clock
`define COE_CLK_MHZ         100
`define COE_REF_MIN_MHZ     30
`define COE_REF_MAX_CYC     (`COE_CLK_MHZ / `COE_REF_MIN_MHZ)

`endif

// ===== rtl/coe_clk_ctrl.v
// Top of the clock output enable control block with serial write port
`timescale 1ns/1ns
`default_nettype none
`include "coe_regs.vh"

// What this block does
// - Disabled pair floats, enabled pair is driven
// - Feedback pair is never disabled by writes
// - Enable writes never cut a clock pulse
// - Supply strap low bypasses and stops PLL
// - Low byte bit 7 is pair 0, reset ones
// - Slow reference with supply strap high floats all outputs, PLL off
// - High byte bits 7,6 are pairs 8,9
module coe_clk_ctrl (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Reference clock and PLL supply strap
    input  wire       ref_clk_true,
    input  wire       pll_supply_strap,
    // Serial bus
    input  wire       serial_clk_pin,
    input  wire       serial_data_in,
    output reg        serial_data_out_q,
    output reg        serial_data_oe_q,
    // Clock output pairs
    output wire [9:0] out_clk_true,
    output wire [9:0] out_clk_comp,
    output wire [9:0] out_clk_oe,
    // Feedback pair
    output reg        fb_out_true_q,
    output reg        fb_out_comp_q,
    output reg        fb_out_oe_q,
    // Status
    output reg        pll_on_q
);

    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_RX   = 4'h2;
    localparam [3:0] ST_ACK  = 4'h4;
    localparam [3:0] ST_SKIP = 4'h8;

    // Constants sized to the registers they meet
    localparam [31:0] REF_MAX_W   = `COE_REF_MAX_CYC;
    localparam [3:0]  REF_MAX     = REF_MAX_W[3:0];
    localparam [7:0]  EN_HIGH_RST = `COE_EN_HIGH_RST;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [1:0] ref_sync_q;
    reg [1:0] strap_sync_q;
    reg [1:0] scl_sync_q;
    reg [1:0] sda_sync_q;
    reg       ref_prev_q;
    reg       scl_prev_q;
    reg       sda_prev_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            ref_sync_q   <= 2'h0;
            strap_sync_q <= 2'h3;
            scl_sync_q   <= 2'h3;
            sda_sync_q   <= 2'h3;
            ref_prev_q   <= 1'b0;
            scl_prev_q   <= 1'b1;
            sda_prev_q   <= 1'b1;
        end else begin
            ref_sync_q   <= {ref_sync_q[0], ref_clk_true};
            strap_sync_q <= {strap_sync_q[0], pll_supply_strap};
            scl_sync_q   <= {scl_sync_q[0], serial_clk_pin};
            sda_sync_q   <= {sda_sync_q[0], serial_data_in};
            ref_prev_q   <= ref_sync_q[1];
            scl_prev_q   <= scl_sync_q[1];
            sda_prev_q   <= sda_sync_q[1];
        end
    end

    wire ref_lvl  = ref_sync_q[1];
    wire scl      = scl_sync_q[1];
    wire sda      = sda_sync_q[1];
    wire ref_rise = ref_lvl & ~ref_prev_q;
    wire scl_rise = scl & ~scl_prev_q;
    wire scl_fall = ~scl & scl_prev_q;
    wire start_ev = scl & scl_prev_q & ~sda & sda_prev_q;
    wire stop_ev  = scl & scl_prev_q & sda & ~sda_prev_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Reference frequency watch and PLL mode
    reg [3:0] ref_cnt_q;
    reg       ref_slow_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            ref_cnt_q  <= 4'h0;
            ref_slow_q <= 1'b1;
            pll_on_q   <= 1'b0;
        end else begin
            if (ref_rise) begin
                ref_cnt_q  <= 4'h0;
                ref_slow_q <= (ref_cnt_q > REF_MAX);
            end else if (ref_cnt_q != 4'hF) begin
                ref_cnt_q <= ref_cnt_q + 4'h1;
                if (ref_cnt_q > REF_MAX) begin
                    ref_slow_q <= 1'b1;
                end
            end
            // Strap low: PLL off; slow reference with PLL active: off too
            pll_on_q <= strap_sync_q[1] & ~ref_slow_q;
        end
    end

    // Float only applies with PLL path selected; bypass passes reference
    wire force_off = strap_sync_q[1] & ref_slow_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial write receiver
    reg [3:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg [2:0] byte_idx_q;
    reg [7:0] en_low_q;
    reg [1:0] en_high_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            state_q           <= ST_IDLE;
            bit_cnt_q         <= 4'h0;
            shift_q           <= 8'h00;
            byte_idx_q        <= 3'h0;
            en_low_q          <= `COE_EN_LOW_RST;
            en_high_q         <= {EN_HIGH_RST[`COE_EN_HIGH_PAIR8],
                                  EN_HIGH_RST[`COE_EN_HIGH_PAIR9]};
            serial_data_out_q <= 1'b0;
            serial_data_oe_q  <= 1'b0;
        end else if (start_ev) begin
            state_q          <= ST_RX;
            bit_cnt_q        <= 4'h0;
            byte_idx_q       <= `COE_IDX_ADDR;
            serial_data_oe_q <= 1'b0;
        end else if (stop_ev) begin
            state_q          <= ST_IDLE;
            serial_data_oe_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    bit_cnt_q <= 4'h0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_q   <= {shift_q[6:0], sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        if (byte_idx_q == `COE_IDX_ADDR &&
                            shift_q != {`COE_DEV_ADDR, 1'b0}) begin
                            // Other address or a read: stay off the bus
                            state_q <= ST_SKIP;
                        end else begin
                            state_q          <= ST_ACK;
                            serial_data_oe_q <= 1'b1;
                            // Command and count bytes are taken and dropped
                            if (byte_idx_q == `COE_IDX_EN_LOW) begin
                                en_low_q <= shift_q;
                            end
                            if (byte_idx_q == `COE_IDX_EN_HIGH) begin
                                en_high_q <= {shift_q[`COE_EN_HIGH_PAIR8],
                                              shift_q[`COE_EN_HIGH_PAIR9]};
                            end
                            if (byte_idx_q != `COE_IDX_LAST) begin
                                byte_idx_q <= byte_idx_q + 3'h1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        serial_data_oe_q <= 1'b0;
                        state_q          <= ST_RX;
                    end
                end
                ST_SKIP: begin
                    serial_data_oe_q <= 1'b0;
                end
                default: begin
                    state_q          <= ST_IDLE;
                    serial_data_oe_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output pairs
    wire [9:0] en_vec = {en_high_q[0], en_high_q[1], en_low_q[0], en_low_q[1],
                         en_low_q[2], en_low_q[3], en_low_q[4], en_low_q[5],
                         en_low_q[6], en_low_q[7]};

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi = gi + 1) begin : g_pair
            coe_pair_gate u_gate (
                .clk        (clk),
                .sys_rst    (sys_rst),
                .ref_lvl    (ref_lvl),
                .en_req     (en_vec[gi]),
                .force_off  (force_off),
                .out_true_q (out_clk_true[gi]),
                .out_comp_q (out_clk_comp[gi]),
                .out_oe_q   (out_clk_oe[gi])
            );
        end
    endgenerate

    // Feedback pair has no enable bit; only a slow reference with supply strap high floats it
    always @(posedge clk) begin
        if (sys_rst) begin
            fb_out_true_q <= 1'b0;
            fb_out_comp_q <= 1'b1;
            fb_out_oe_q   <= 1'b0;
        end else begin
            fb_out_true_q <= ref_lvl;
            fb_out_comp_q <= ~ref_lvl;
            fb_out_oe_q   <= ~force_off;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/coe_pair_gate.v
// Runt-free enable gate for one differential output pair
`timescale 1ns/1ns
`default_nettype none

module coe_pair_gate (
    // Clock and reset
    input  wire clk,
    input  wire sys_rst,
    // Control
    input  wire ref_lvl,
    input  wire en_req,
    input  wire force_off,
    // Pair outputs
    output reg  out_true_q,
    output reg  out_comp_q,
    output reg  out_oe_q
);

    reg en_q;

    always @(posedge clk) begin
        if (sys_rst) begin
            en_q       <= 1'b1;
            out_true_q <= 1'b0;
            out_comp_q <= 1'b1;
            out_oe_q   <= 1'b0;
        end else begin
            // New enable only taken in the low phase, so no pulse is cut
            if (!ref_lvl) begin
                en_q <= en_req;
            end
            out_true_q <= ref_lvl;
            out_comp_q <= ~ref_lvl;
            out_oe_q   <= en_q & ~force_off;
        end
    end

endmodule

`default_nettype wire
